//--- core/hitless_switch_sequencer.sv
// hitless switch and phase build-out sequencer for the clock PLL
// assumes lock, alignment and phase-error inputs synchronous to mclk
//
// Summary of operation
// - arm only once the PLL reports lock on the current reference.
// - while armed, a 4 ns phase error or a reference failure starts the switching sequence.
// - in automatic mode the sequence runs with alternate reference reselect.
// - in manual mode the sequence runs but the reference is kept.
// - first step disables phase detector and selects 2100k narrow resistor.
// - with build-out fitted, shift feedback by whole oscillator cycles.
// - after build-out, re-enable the phase detector to reacquire lock.
// - start resume timer after eight consecutive cycles within 2 ns.
// - resume timer expires after 175 ns rounded down to whole mclk cycles, so one 100 ns cycle.
// - on expiry return the resistor to the bandwidth select level (100k wide when select is low) and re-arm.
// - bandwidth select low means wide 100k, high means narrow 2100k.
// - the function exists only when the build-time option enables it.
// - loss-of-lock fires on a 4 ns phase transient.
// - at most one automatic reselection per arming; mode low-high re-arms.
`timescale 1ns/1ps
`default_nettype none
module hitless_switch_sequencer #(
	parameter bit HS_FITTED  = 1'b1,
	parameter bit PBO_FITTED = 1'b1,
	parameter int SHIFT_W    = 4,
	parameter int RESUME_CYC = hss_pkg::RESUME_CYCLES,
	parameter int ALIGN_CYC  = hss_pkg::ALIGN_COUNT
) (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic               pll_locked,
	input  wire logic               phase_err_4ns,
	input  wire logic               phase_within_2ns,
	input  wire logic               auto_mode,
	input  wire logic               narrow_bandwidth_select_in,
	input  wire logic [SHIFT_W-1:0] best_edge_shift,
	input  wire logic               ref_fail_in,
	output logic                    lock_lost_flag,
	output logic                    phase_det_enable,
	output logic                    loop_res_narrow,
	output logic                    ref_select,
	output logic                    reselect_pulse,
	output logic [SHIFT_W-1:0]      feedback_shift,
	output logic                    feedback_shift_load,
	output logic                    hitless_switch_function,
	output logic                    phase_buildout_function,
	output logic                    sequence_busy
);
	localparam int CW = 8;

	hss_pkg::hss_state_t state;
	hss_pkg::hss_state_t next_state;
	logic          hs_narrow;
	logic          auto_d;
	logic          auto_armed;
	logic [CW-1:0] timer;
	logic [CW-1:0] next_timer;

	hss_run_if #(.W(CW)) run ();

	// alignment run counter: eight in a row within the window
	hss_run_counter #(.W(CW)) u_align (
		.mclk  (mclk),
		.rst_n (rst_n),
		.run   (run)
	);

	wire loss_event  = phase_err_4ns || ref_fail_in;
	wire armed       = (state == hss_pkg::HSS_ARMED);
	wire trigger     = HS_FITTED && armed && loss_event;
	wire auto_rise   = auto_mode && !auto_d;
	wire do_reselect = trigger && auto_mode && auto_armed;
	wire timer_done  = (timer == CW'(RESUME_CYC));
	wire next_narrow = (next_state == hss_pkg::HSS_HOLD) ||
		(next_state == hss_pkg::HSS_BUILDOUT) ||
		(next_state == hss_pkg::HSS_RELOCK) ||
		(next_state == hss_pkg::HSS_RESUME);
	wire next_pd_off = (next_state == hss_pkg::HSS_HOLD) ||
		(next_state == hss_pkg::HSS_BUILDOUT);

	assign run.clear = (state != hss_pkg::HSS_RELOCK);
	assign run.hit   = phase_within_2ns;
	assign run.limit = CW'(ALIGN_CYC);

	// sequence steps
	always_comb begin
		next_state = state;
		case (state)
		hss_pkg::HSS_IDLE: begin
			if (HS_FITTED && pll_locked) begin
				next_state = hss_pkg::HSS_ARMED;
			end
		end
		hss_pkg::HSS_ARMED: begin
			if (trigger) begin
				next_state = hss_pkg::HSS_HOLD;
			end
		end
		hss_pkg::HSS_HOLD: begin
			next_state = PBO_FITTED ? hss_pkg::HSS_BUILDOUT :
				hss_pkg::HSS_RELOCK;
		end
		hss_pkg::HSS_BUILDOUT: begin
			next_state = hss_pkg::HSS_RELOCK;
		end
		hss_pkg::HSS_RELOCK: begin
			if (run.done) begin
				next_state = hss_pkg::HSS_RESUME;
			end
		end
		hss_pkg::HSS_RESUME: begin
			if (timer_done) begin
				next_state = hss_pkg::HSS_ARMED;
			end
		end
		default: next_state = hss_pkg::HSS_IDLE;
		endcase
	end

	// resume timer counts only in the resume step
	assign next_timer = (state == hss_pkg::HSS_RESUME && !timer_done) ?
		timer + CW'(1) : '0;

	// state, timer and reselection bookkeeping
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state      <= hss_pkg::HSS_IDLE;
			timer      <= '0;
			auto_d     <= 1'b0;
			auto_armed <= 1'b0;
		end else begin
			state  <= next_state;
			timer  <= next_timer;
			auto_d <= auto_mode;
			if (!auto_mode) begin
				auto_armed <= 1'b0;
			end else if (auto_rise) begin
				auto_armed <= 1'b1;
			end else if (do_reselect) begin
				auto_armed <= 1'b0;
			end
		end
	end

	// registered outputs toward the analog loop
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hs_narrow           <= 1'b0;
			loop_res_narrow     <= hss_pkg::RES_WIDE;
			phase_det_enable    <= 1'b1;
			ref_select          <= 1'b0;
			reselect_pulse      <= 1'b0;
			feedback_shift      <= '0;
			feedback_shift_load <= 1'b0;
			lock_lost_flag      <= 1'b0;
			sequence_busy       <= 1'b0;
		end else begin
			hs_narrow        <= next_narrow;
			loop_res_narrow  <= next_narrow ||
				narrow_bandwidth_select_in;
			phase_det_enable <= !next_pd_off;
			reselect_pulse   <= do_reselect;
			if (do_reselect) begin
				ref_select <= !ref_select;
			end
			feedback_shift_load <= PBO_FITTED &&
				(state == hss_pkg::HSS_HOLD);
			if (PBO_FITTED && state == hss_pkg::HSS_HOLD) begin
				feedback_shift <= best_edge_shift;
			end
			lock_lost_flag <= loss_event || !pll_locked;
			sequence_busy  <= !(next_state == hss_pkg::HSS_ARMED ||
				next_state == hss_pkg::HSS_IDLE);
		end
	end

	// build option straps shown as constant levels
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hitless_switch_function <= 1'b0;
			phase_buildout_function <= 1'b0;
		end else begin
			hitless_switch_function <= HS_FITTED;
			phase_buildout_function <= HS_FITTED && PBO_FITTED;
		end
	end
endmodule
`default_nettype wire

//--- core/hss_pkg.sv
// package for the hitless switch sequencer: timing constants and states
// assumes a 10 MHz sequencer clock mclk
package hss_pkg;
	localparam int  CLK_PERIOD_NS     = 100;
	localparam int  RESUME_TIME_NS    = 175;
	// longest time rounds down, but never below one cycle
	localparam int  RESUME_CYCLES_RAW = RESUME_TIME_NS / CLK_PERIOD_NS;
	localparam int  RESUME_CYCLES     = (RESUME_CYCLES_RAW < 1) ? 1 :
		RESUME_CYCLES_RAW;
	localparam int  ALIGN_COUNT       = 8;
	localparam int  ALIGN_WINDOW_NS   = 2;
	localparam int  LOSS_TRANSIENT_NS = 4;
	localparam logic [7:0] STEP_RST   = 8'h00;
	localparam logic RES_WIDE         = 1'b0;
	localparam logic RES_NARROW       = 1'b1;

	typedef enum logic [2:0] {
		HSS_IDLE,
		HSS_ARMED,
		HSS_HOLD,
		HSS_BUILDOUT,
		HSS_RELOCK,
		HSS_RESUME
	} hss_state_t;
endpackage

//--- core/hss_run_if.sv
// interface carrying a run-length count request between sequencer modules
// assumes one clock domain, driven by mclk
`timescale 1ns/1ps
`default_nettype none
interface hss_run_if #(parameter int W = 8);
	logic         clear;
	logic         hit;
	logic [W-1:0] limit;
	logic         done;
	modport owner (output clear, output hit, output limit, input done);
	modport counter (input clear, input hit, input limit, output done);
endinterface
`default_nettype wire

//--- core/hss_run_counter.sv
// consecutive-event counter: done once hit has been seen limit times in a row
// assumes synchronous reset and a single clock
`timescale 1ns/1ps
`default_nettype none
module hss_run_counter #(
	parameter int W = 8
) (
	input  wire logic   mclk,
	input  wire logic   rst_n,
	hss_run_if.counter  run
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	// any miss restarts the run; the count saturates at the limit
	assign next_count = (run.clear || !run.hit) ? '0 :
		(count == run.limit) ? count : count + W'(1);
	assign run.done   = (count == run.limit);

	// run length register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

//--- testbench/hss_props.sv
// checker: sequencer outputs tied to their causes
// assumes bind to the sequencer top, both options fitted
`timescale 1ns/1ps
`default_nettype none
module hss_props (
	input wire logic mclk, rst_n, pll_locked, phase_err_4ns, ref_fail_in,
	input wire logic phase_within_2ns, auto_mode, reselect_pulse,
	input wire logic narrow_bandwidth_select_in, phase_det_enable,
	input wire logic loop_res_narrow, feedback_shift_load, sequence_busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [3:0] run;
	// aligned cycles in a row while the detector compares
	always_ff @(posedge mclk)
		run <= (rst_n && phase_det_enable && phase_within_2ns) ?
			run + {3'h0, run != 4'hF} : 4'h0;
	// loss event while locked and idle
	sequence trig_s;
		pll_locked ##1 (pll_locked && !sequence_busy &&
			(phase_err_4ns || ref_fail_in));
	endsequence
	trig_take_a: assert property (trig_s |=>
		(loop_res_narrow && !phase_det_enable && sequence_busy))
		else $error("start missed");
	pd_gap_a: assert property ($fell(phase_det_enable) |=>
		(feedback_shift_load && !phase_det_enable) ##1 phase_det_enable)
		else $error("detector gap");
	ext_narrow_a: assert property (narrow_bandwidth_select_in |=>
		loop_res_narrow) else $error("narrow lost");
	relock_run_a: assert property ($fell(sequence_busy) |->
		run >= 4'h8) else $error("early resume");
	resume_time_a: assert property (sequence_busy && run == 4'h8 |->
		##[1:5] !sequence_busy) else $error("late resume");
	wide_back_a: assert property ($fell(sequence_busy) |->
		!loop_res_narrow || $past(narrow_bandwidth_select_in))
		else $error("still narrow");
	resel_once_a: assert property (reselect_pulse |->
		$rose(sequence_busy)) else $error("extra reselect");
	resel_auto_a: assert property (reselect_pulse |->
		$past(auto_mode)) else $error("manual reselect");
endmodule
bind hitless_switch_sequencer hss_props u_props (.*);
`default_nettype wire

//--- testbench/hss_far_model.sv
// far-side model: reference and feedback alignment at the detector
// assumes detector enable from the sequencer; slip forces a miss
`timescale 1ns/1ps
`default_nettype none
module hss_far_model (
	input  wire logic mclk, phase_det_enable, slip,
	output wire logic phase_within_2ns
);
	logic aligned = 1'b0;
	// clocks agree only while compared, taken off the falling edge
	always @(negedge mclk) aligned <= phase_det_enable;
	assign phase_within_2ns = aligned && !slip;
endmodule
`default_nettype wire

//--- testbench/tb.sv
// testbench: arming, switching in both modes, resume
// assumes the far-side model answers the alignment input
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb;
	logic mclk, rst_n, pll_locked, phase_err_4ns, phase_within_2ns, slip;
	logic auto_mode, narrow_bandwidth_select_in, ref_fail_in, ref_select;
	logic lock_lost_flag, phase_det_enable, loop_res_narrow, sequence_busy;
	logic reselect_pulse, feedback_shift_load, hitless_switch_function;
	logic phase_buildout_function;
	logic [3:0] best_edge_shift, feedback_shift;
	int fails = 0;
	int comparisons = 0;
	hitless_switch_sequencer dut (.*);
	hss_far_model far (.mclk, .phase_det_enable, .slip, .phase_within_2ns);
	// clock, and a watchdog far past the expected run
	initial begin mclk = 1'b0; forever #50 mclk = ~mclk; end
	initial begin #100000 fails++; close_out; end
	task automatic cyc(int n); repeat (n) @(negedge mclk); endtask
	task automatic close_out;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one loss event, then the sequence up to re-arming
	task automatic run_seq(logic src, logic rs, logic [3:0] sh, logic sl);
		logic r0;
		int n;
		r0 = ref_select;
		best_edge_shift = sh;
		{phase_err_4ns, ref_fail_in} = {!src, src};
		cyc(1);
		{phase_err_4ns, ref_fail_in} = 2'h0;
		`CK("lost", 1'b1, lock_lost_flag)
		`CK("resel", rs, reselect_pulse)
		cyc(1);
		`CK("ref", r0 ^ rs, ref_select)
		cyc(3);
		`CK("shift", sh, feedback_shift)
		{slip, phase_err_4ns} = {sl, sl};
		cyc(1);
		{slip, phase_err_4ns} = 2'h0;
		for (n = 0; sequence_busy !== 1'b0 && n < 40; n++) cyc(1);
		`CK("span", 1'b1, n >= (sl ? 9 : 6))
		`CK("wide", narrow_bandwidth_select_in, loop_res_narrow)
	endtask
	// fitted options, and no start before lock
	task automatic t_reset;
		cyc(1);
		`CK("hs", 1'b1, hitless_switch_function)
		`CK("pbo", 1'b1, phase_buildout_function)
		phase_err_4ns = 1'b1;
		cyc(3);
		`CK("unarmed", 1'b0, sequence_busy)
		phase_err_4ns = 1'b0;
		pll_locked = 1'b1;
		cyc(2);
	endtask
	// manual mode, an alignment slip in mid-sequence, external narrow select
	task automatic t_manual;
		run_seq(1'b0, 1'b0, 4'hF, 1'b0);
		run_seq(1'b1, 1'b0, 4'h0, 1'b1);
		narrow_bandwidth_select_in = 1'b1;
		cyc(2);
		`CK("ext", 1'b1, loop_res_narrow)
		run_seq(1'b0, 1'b0, 4'h9, 1'b0);
		narrow_bandwidth_select_in = 1'b0;
	endtask
	// automatic mode: one reselection per arming
	task automatic t_auto;
		auto_mode = 1'b1;
		cyc(2);
		run_seq(1'b1, 1'b1, 4'h7, 1'b0);
		run_seq(1'b1, 1'b0, 4'h1, 1'b0);
		auto_mode = 1'b0;
		cyc(1);
		auto_mode = 1'b1;
		cyc(2);
		run_seq(1'b0, 1'b1, 4'h8, 1'b0);
	endtask
	initial begin
		{rst_n, pll_locked, phase_err_4ns, ref_fail_in, slip} = 5'h00;
		{auto_mode, narrow_bandwidth_select_in, best_edge_shift} = 6'h00;
		cyc(3);
		rst_n = 1'b1;
		t_reset;
		t_manual;
		t_auto;
		close_out;
	end
endmodule
`default_nettype wire
